//--- bench/dcsm_sensor_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dcsm_sensor_model (
  // Contact commands
  input wire logic act_a_i,
  input wire logic act_b_i,
  input wire logic anti_i,
  // Sensor pins
  output logic first_channel_no_terminal_o,
  output logic second_channel_nc_terminal_o
);
  // A normally-open contact reads 1 when the guard is closed.
  // Only antivalent wiring inverts it, so both pins read equal when stuck.
  assign first_channel_no_terminal_o = anti_i ? !act_a_i : act_a_i;
  assign second_channel_nc_terminal_o = act_b_i;
endmodule // dcsm_sensor_model

//--- bench/tb_dcsm_monitor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_dcsm_monitor;
  localparam int unsigned SYNC_S = 20;
  localparam int unsigned SYNC_L = 40;
  localparam int unsigned IL_MON = 30;
  localparam int unsigned IL_CLR = 50;
  localparam int unsigned ACT = 5;
  localparam int unsigned SWON = 10;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic start_i = 1'b0;
  logic [1:0] app_fn_i = 2'h0;
  logic init_done_i = 1'b0;
  logic init_err_i = 1'b0;
  logic act_a = 1'b0;
  logic act_b = 1'b0;
  logic pin_a;
  logic pin_b;
  logic safety_out_o;
  logic safe_state_o;
  logic sync_alert_o;
  logic equal_alert_o;
  logic interlock_alert_o;
  logic error_o;
  int fail_count = 0;
  int cmp_count = 0;
  int n;

  always #12.5 ref_clk_i = !ref_clk_i;

  dcsm_sensor_model i_dcsm_sensor_model (
    .act_a_i(act_a),
    .act_b_i(act_b),
    .anti_i(app_fn_i == dcsm_pkg::FN_ANTI),
    .first_channel_no_terminal_o(pin_a),
    .second_channel_nc_terminal_o(pin_b)
  );

  dcsm_monitor #(
    .SYNC_SHORT_CYC(SYNC_S),
    .SYNC_LONG_CYC(SYNC_L),
    .IL_MON_CYC(IL_MON),
    .IL_CLR_CYC(IL_CLR),
    .ACT_DELAY_CYC(ACT),
    .SWON_DELAY_CYC(SWON)
  ) i_dcsm_monitor (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .first_channel_no_terminal_i(pin_a),
    .second_channel_nc_terminal_i(pin_b),
    .start_i(start_i),
    .app_fn_i(app_fn_i),
    .init_done_i(init_done_i),
    .init_err_i(init_err_i),
    .safety_out_o(safety_out_o),
    .safe_state_o(safe_state_o),
    .sync_alert_o(sync_alert_o),
    .equal_alert_o(equal_alert_o),
    .interlock_alert_o(interlock_alert_o),
    .error_o(error_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Waiting ends 1 ns past the edge so that the design's updates have landed.
  task cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask

  task chk(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error %s expected %b seen %b", name, exp, got);
      fail_count++;
    end
  endtask

  task drv(input logic a, input logic b, input logic s);
    @(posedge ref_clk_i);
    act_a <= a;
    act_b <= b;
    start_i <= s;
    cyc(0);
  endtask

  task wait_out(input logic exp, input int max);
    n = 0;
    while (safety_out_o !== exp)
    begin
      if (n == max)
      begin
        $display("Error safety_out_o wait expected %b seen %b", exp,
                 safety_out_o);
        fail_count++;
        end_sim;
      end
      cyc(1);
      n++;
    end
  endtask

  task do_reset(input dcsm_pkg::dcsm_fn_type fn);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    app_fn_i <= fn;
    init_done_i <= 1'b0;
    init_err_i <= 1'b0;
    act_a <= 1'b0;
    act_b <= 1'b0;
    start_i <= 1'b0;
    cyc(3);
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    init_done_i <= 1'b1;
    cyc(SWON + 4);
    chk("safe_state_o", 1'b1, safe_state_o);
    chk("error_o", 1'b0, error_o);
  endtask

  task energize;
    drv(1'b1, 1'b1, 1'b1);
    wait_out(1'b1, ACT + 8);
    chk("activation delay", 1'b1, n >= ACT);
    chk("safe_state_o", 1'b0, safe_state_o);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task t_init;
    do_reset(dcsm_pkg::FN_PLAIN);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    init_done_i <= 1'b0;
    cyc(3);
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    init_err_i <= 1'b1;
    act_a <= 1'b1;
    act_b <= 1'b1;
    start_i <= 1'b1;
    cyc(2);
    chk("error_o", 1'b1, error_o);
    cyc(SWON + ACT + 8);
    chk("safety_out_o", 1'b0, safety_out_o);
  endtask

  task t_plain;
    do_reset(dcsm_pkg::FN_PLAIN);
    drv(1'b1, 1'b1, 1'b0);
    cyc(ACT + 20);
    chk("safety_out_o", 1'b0, safety_out_o);
    chk("safe_state_o", 1'b1, safe_state_o);
    energize;
    drv(1'b0, 1'b1, 1'b1);
    wait_out(1'b0, 4);
    chk("safe_state_o", 1'b1, safe_state_o);
  endtask

  task t_sync;
    do_reset(dcsm_pkg::FN_SYNC);
    drv(1'b1, 1'b0, 1'b1);
    cyc(SYNC_L + 6);
    chk("sync_alert_o", 1'b1, sync_alert_o);
    drv(1'b1, 1'b1, 1'b1);
    cyc(ACT + 10);
    chk("safety_out_o", 1'b0, safety_out_o);
    drv(1'b0, 1'b0, 1'b1);
    cyc(5);
    // A lag beyond the short window but inside the long one is accepted.
    drv(1'b1, 1'b0, 1'b1);
    cyc(SYNC_S + 6);
    energize;
    drv(1'b1, 1'b0, 1'b1);
    wait_out(1'b0, 4);
  endtask

  task t_anti;
    do_reset(dcsm_pkg::FN_ANTI);
    energize;
    drv(1'b0, 1'b0, 1'b1);
    wait_out(1'b0, 4);
    drv(1'b1, 1'b0, 1'b1);
    cyc(SYNC_S - 4);
    chk("equal_alert_o", 1'b0, equal_alert_o);
    cyc(10);
    chk("equal_alert_o", 1'b1, equal_alert_o);
    chk("safety_out_o", 1'b0, safety_out_o);
  endtask

  task t_il_late;
    do_reset(dcsm_pkg::FN_SYNC_IL);
    energize;
    drv(1'b0, 1'b1, 1'b1);
    wait_out(1'b0, 4);
    cyc(IL_MON - 8);
    chk("interlock_alert_o", 1'b0, interlock_alert_o);
    cyc(14);
    chk("interlock_alert_o", 1'b1, interlock_alert_o);
    drv(1'b1, 1'b1, 1'b1);
    cyc(ACT + 10);
    chk("safety_out_o", 1'b0, safety_out_o);
    drv(1'b0, 1'b0, 1'b1);
    cyc(IL_CLR - 10);
    chk("interlock_alert_o", 1'b1, interlock_alert_o);
    cyc(16);
    chk("interlock_alert_o", 1'b0, interlock_alert_o);
    energize;
  endtask

  task t_il_early;
    do_reset(dcsm_pkg::FN_SYNC_IL);
    energize;
    drv(1'b0, 1'b1, 1'b1);
    cyc(6);
    drv(1'b1, 1'b1, 1'b1);
    cyc(5);
    chk("interlock_alert_o", 1'b1, interlock_alert_o);
    chk("safety_out_o", 1'b0, safety_out_o);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    t_init;
    t_plain;
    t_sync;
    t_anti;
    t_il_late;
    t_il_early;
    end_sim;
  end
endmodule // tb_dcsm_monitor

//--- common/dcsm_chan_if.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
interface dcsm_chan_if;
  logic antivalent;
  logic sync_en;
  logic [31:0] sync_cyc;
  logic a_act;
  logic b_act;
  logic sync_fail;
  logic equal_alert;

  modport dec (
    input antivalent,
    input sync_en,
    input sync_cyc,
    output a_act,
    output b_act,
    output sync_fail,
    output equal_alert
  );

  modport mon (
    output antivalent,
    output sync_en,
    output sync_cyc,
    input a_act,
    input b_act,
    input sync_fail,
    input equal_alert
  );
endinterface

//--- common/dcsm_pkg.sv
////////////////////////////////////////////////////////////////////////////////
package dcsm_pkg;

  // Internal clock rate in kHz (40 MHz).
  localparam int unsigned CLK_KHZ = 40000;

  // Window and delay times in milliseconds.
  localparam int unsigned SYNC_SHORT_MS = 100;
  localparam int unsigned SYNC_LONG_MS = 500;
  localparam int unsigned IL_MON_MS = 200;
  localparam int unsigned IL_CLR_MS = 1000;
  localparam int unsigned ACT_DELAY_MS = 50;
  localparam int unsigned SWON_DELAY_MS = 1000;

  // Width of every window counter.
  localparam int unsigned CNT_W = 32;

  // Reset values of the pin synchronisers and counters.
  localparam logic [1:0] CHAN_RST = 2'h0;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [31:0] CNT_RST = 32'h0;

  // Application functions selectable on the configuration pins.
  typedef enum logic [1:0] {
    FN_PLAIN,
    FN_SYNC,
    FN_ANTI,
    FN_SYNC_IL
  } dcsm_fn_type;

  // Converts a time in milliseconds to internal clock cycles.
  function automatic int unsigned ms_to_cyc(input int unsigned ms);
    return ms * CLK_KHZ;
  endfunction

endpackage

//--- design/dcsm_chan_decode.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dcsm_chan_decode (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Sensor pins
  input wire logic first_channel_no_terminal_i,
  input wire logic second_channel_nc_terminal_i,
  // Decoded channel state
  dcsm_chan_if.dec chan
);

  logic [1:0] meta_reg;
  logic [1:0] pin_reg;
  logic [31:0] mism_cnt_reg;
  logic sync_fail_reg;
  logic equal_alert_reg;
  logic mismatch;
  logic both_off;
  logic win_end;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      meta_reg <= dcsm_pkg::CHAN_RST;
      pin_reg <= dcsm_pkg::CHAN_RST;
    end
    else
    begin
      meta_reg <= {second_channel_nc_terminal_i, first_channel_no_terminal_i};
      pin_reg <= meta_reg;
    end
  end

  // The open contact is inverted only for the antivalent pair.
  assign chan.a_act = chan.antivalent ? !pin_reg[0] : pin_reg[0];
  assign chan.b_act = pin_reg[1];
  assign mismatch = chan.a_act ^ chan.b_act;
  assign both_off = !chan.a_act && !chan.b_act;
  assign win_end = mismatch && (mism_cnt_reg == chan.sync_cyc - 32'h1);
  assign chan.sync_fail = sync_fail_reg;
  assign chan.equal_alert = equal_alert_reg;

  //////////////////////////////////////////////////////////////////////////////
  // The window restarts on the first edge that splits the channels.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      mism_cnt_reg <= dcsm_pkg::CNT_RST;
    else if (!mismatch)
      mism_cnt_reg <= dcsm_pkg::CNT_RST;
    else if (mism_cnt_reg != chan.sync_cyc)
      mism_cnt_reg <= mism_cnt_reg + 32'h1;
  end

  // Failure holds until both channels rest, so a late second channel
  // can never complete an activation on its own.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      sync_fail_reg <= 1'b0;
    else if (chan.sync_en && win_end)
      sync_fail_reg <= 1'b1;
    else if (both_off)
      sync_fail_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      equal_alert_reg <= 1'b0;
    else if (chan.antivalent && win_end)
      equal_alert_reg <= 1'b1;
    else if (both_off)
      equal_alert_reg <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_anti_on;
    chan.antivalent && !pin_reg[0] && pin_reg[1] |-> chan.a_act && chan.b_act;
  endproperty
  a_anti_on: assert property (p_anti_on)
    else $error("antivalent 0/1 not decoded as activated");

  property p_anti_off;
    chan.antivalent && pin_reg[0] && !pin_reg[1] |-> both_off;
  endproperty
  a_anti_off: assert property (p_anti_off)
    else $error("antivalent 1/0 not decoded as deactivated");

  property p_equal;
    $rose(equal_alert_reg) |->
      $past(chan.antivalent) && $past(mism_cnt_reg) == chan.sync_cyc - 32'h1;
  endproperty
  a_equal: assert property (p_equal)
    else $error("equal level alert not at end of sync window");

  property p_sync_fail;
    chan.sync_en && win_end |=> sync_fail_reg;
  endproperty
  a_sync_fail: assert property (p_sync_fail)
    else $error("sync window expired without failure");

endmodule // dcsm_chan_decode

//--- design/dcsm_monitor.sv
`timescale 1ns/1ps
// Function
// - Synchronized function: second input late blocks output.
// - No start condition keeps outputs off.
// - Output on within activation delay after start.
// - Deactivation switches output off within response time.
// - Interlock function: both deactivate within window.
// - Antivalent open 0, closed 1 means activated.
// - Antivalent open 1, closed 0 means deactivated.
// - Antivalent equal levels beyond sync time alert.
// - Unsynchronized activation leaves the safety output off.
// - Function selects sync mechanism and sync time.
// - Antivalent decoding only for antivalent function.
// - Any deactivation returns to de-energized run.
// - Interlock window 200 ms, alert, block energizing.
// - Interlock clears after one second both deactivated.
// - Early re-activation raises interlock alert at once.
// - Power-on initialization, switch-on delay, or error.
module dcsm_monitor #(
  parameter int unsigned SYNC_SHORT_CYC =
    dcsm_pkg::ms_to_cyc(dcsm_pkg::SYNC_SHORT_MS),
  parameter int unsigned SYNC_LONG_CYC =
    dcsm_pkg::ms_to_cyc(dcsm_pkg::SYNC_LONG_MS),
  parameter int unsigned IL_MON_CYC = dcsm_pkg::ms_to_cyc(dcsm_pkg::IL_MON_MS),
  parameter int unsigned IL_CLR_CYC = dcsm_pkg::ms_to_cyc(dcsm_pkg::IL_CLR_MS),
  parameter int unsigned ACT_DELAY_CYC =
    dcsm_pkg::ms_to_cyc(dcsm_pkg::ACT_DELAY_MS),
  parameter int unsigned SWON_DELAY_CYC =
    dcsm_pkg::ms_to_cyc(dcsm_pkg::SWON_DELAY_MS)
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Sensor and start pins
  input wire logic first_channel_no_terminal_i,
  input wire logic second_channel_nc_terminal_i,
  input wire logic start_i,
  // Application function pins
  input wire logic [1:0] app_fn_i,
  // Self-test results
  input wire logic init_done_i,
  input wire logic init_err_i,
  // Outputs
  output logic safety_out_o,
  output logic safe_state_o,
  output logic sync_alert_o,
  output logic equal_alert_o,
  output logic interlock_alert_o,
  output logic error_o
);

  typedef enum logic [1:0] {ST_INIT, ST_DEEN, ST_EN, ST_ERR} dcsm_state_type;

  dcsm_chan_if chan ();

  dcsm_state_type state_reg;
  dcsm_state_type state_next;
  dcsm_pkg::dcsm_fn_type fn_reg;
  logic [2:0] cfg_meta_reg;
  logic [2:0] cfg_pin_reg;
  logic [31:0] swon_cnt_reg;
  logic [31:0] act_cnt_reg;
  logic [31:0] il_cnt_reg;
  logic [31:0] clr_cnt_reg;
  logic both_act_d_reg;
  logic il_watch_reg;
  logic il_reg;
  logic start_act;
  logic il_en;
  logic both_act;
  logic both_off;
  logic sync_block;
  logic go;
  logic il_early;
  logic il_late;

  if (SYNC_SHORT_CYC < 2 || SYNC_LONG_CYC < 2 || IL_MON_CYC < 2 ||
      IL_CLR_CYC < 2 || ACT_DELAY_CYC < 1 || SWON_DELAY_CYC < 1)
  begin : g_check
    $error("dcsm_monitor: window counts too small");
  end

  dcsm_chan_decode u_decode (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .first_channel_no_terminal_i(first_channel_no_terminal_i),
    .second_channel_nc_terminal_i(second_channel_nc_terminal_i),
    .chan(chan.dec)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Start and function pins pass two flops before any logic sees them.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      cfg_meta_reg <= dcsm_pkg::CFG_RST;
      cfg_pin_reg <= dcsm_pkg::CFG_RST;
    end
    else
    begin
      cfg_meta_reg <= {app_fn_i, start_i};
      cfg_pin_reg <= cfg_meta_reg;
    end
  end

  // The function is frozen on leaving initialization, so pin changes
  // during run cannot weaken monitoring.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      fn_reg <= dcsm_pkg::FN_PLAIN;
    else if (state_reg == ST_INIT)
      fn_reg <= dcsm_pkg::dcsm_fn_type'(cfg_pin_reg[2:1]);
  end

  assign start_act = cfg_pin_reg[0];
  assign chan.antivalent = (fn_reg == dcsm_pkg::FN_ANTI);
  assign chan.sync_en = (fn_reg != dcsm_pkg::FN_PLAIN);
  assign chan.sync_cyc = (fn_reg == dcsm_pkg::FN_ANTI) ?
    SYNC_SHORT_CYC : SYNC_LONG_CYC;
  assign il_en = (fn_reg == dcsm_pkg::FN_SYNC_IL);
  assign both_act = chan.a_act && chan.b_act;
  assign both_off = !chan.a_act && !chan.b_act;
  assign sync_block = chan.sync_en && chan.sync_fail;
  assign go = start_act && both_act && !sync_block && !il_reg;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT:
        if (init_err_i)
          state_next = ST_ERR;
        else if (init_done_i && swon_cnt_reg == SWON_DELAY_CYC - 1)
          state_next = ST_DEEN;
      ST_DEEN:
        if (go && act_cnt_reg == ACT_DELAY_CYC - 1)
          state_next = ST_EN;
      ST_EN:
        if (!both_act || il_reg)
          state_next = ST_DEEN;
      ST_ERR:
        state_next = ST_ERR;
      default:
        state_next = ST_ERR;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      state_reg <= ST_INIT;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      swon_cnt_reg <= dcsm_pkg::CNT_RST;
    else if (state_reg == ST_INIT && init_done_i)
      swon_cnt_reg <= swon_cnt_reg + 32'h1;
    else
      swon_cnt_reg <= dcsm_pkg::CNT_RST;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      act_cnt_reg <= dcsm_pkg::CNT_RST;
    else if (state_reg == ST_DEEN && go)
      act_cnt_reg <= act_cnt_reg + 32'h1;
    else
      act_cnt_reg <= dcsm_pkg::CNT_RST;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interlock window opens when one channel leaves the fully active state.
  assign il_early = il_watch_reg && both_act;
  assign il_late = il_watch_reg && !both_off && !both_act &&
    il_cnt_reg == IL_MON_CYC - 1;

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      both_act_d_reg <= 1'b0;
      il_watch_reg <= 1'b0;
      il_cnt_reg <= dcsm_pkg::CNT_RST;
    end
    else
    begin
      both_act_d_reg <= both_act;
      if (il_en && both_act_d_reg && !both_act && !both_off)
      begin
        il_watch_reg <= 1'b1;
        il_cnt_reg <= dcsm_pkg::CNT_RST;
      end
      else if (both_off || il_early || il_late)
        il_watch_reg <= 1'b0;
      else if (il_watch_reg)
        il_cnt_reg <= il_cnt_reg + 32'h1;
    end
  end

  // Setting wins over clearing; clearing needs an unbroken rest second.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      il_reg <= 1'b0;
    else if (il_early || il_late)
      il_reg <= 1'b1;
    else if (both_off && clr_cnt_reg == IL_CLR_CYC - 1)
      il_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      clr_cnt_reg <= dcsm_pkg::CNT_RST;
    else if (il_reg && both_off)
      clr_cnt_reg <= clr_cnt_reg + 32'h1;
    else
      clr_cnt_reg <= dcsm_pkg::CNT_RST;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      safety_out_o <= 1'b0;
      safe_state_o <= 1'b1;
      sync_alert_o <= 1'b0;
      equal_alert_o <= 1'b0;
      interlock_alert_o <= 1'b0;
      error_o <= 1'b0;
    end
    else
    begin
      safety_out_o <= (state_next == ST_EN);
      safe_state_o <= (state_next != ST_EN);
      sync_alert_o <= sync_block;
      equal_alert_o <= chan.equal_alert;
      interlock_alert_o <= il_reg;
      error_o <= (state_next == ST_ERR);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_start_gate;
    state_reg != ST_EN && !start_act |=> !safety_out_o;
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("output energized without start condition");

  property p_sync_gate;
    state_reg == ST_DEEN && sync_block |=> !safety_out_o;
  endproperty
  a_sync_gate: assert property (p_sync_gate)
    else $error("output energized after sync failure");

  property p_sync_rise;
    $rose(safety_out_o) |-> !$past(sync_block) && $past(both_act);
  endproperty
  a_sync_rise: assert property (p_sync_rise)
    else $error("output rose without synchronized activation");

  property p_act_delay;
    state_reg == ST_DEEN && go && act_cnt_reg == ACT_DELAY_CYC - 1
      |=> safety_out_o && state_reg == ST_EN;
  endproperty
  a_act_delay: assert property (p_act_delay)
    else $error("output not on at activation delay");

  property p_resp;
    safety_out_o && !both_act |=> !safety_out_o && safe_state_o;
  endproperty
  a_resp: assert property (p_resp)
    else $error("output not off after deactivation");

  property p_deen;
    state_reg == ST_EN && !both_act |=> state_reg == ST_DEEN;
  endproperty
  a_deen: assert property (p_deen)
    else $error("deactivation did not reach de-energized run");

  sequence s_il_timeout;
    il_en && il_watch_reg && !both_off && !both_act &&
      il_cnt_reg == IL_MON_CYC - 1;
  endsequence
  sequence s_il_raised;
    il_reg ##1 interlock_alert_o;
  endsequence
  property p_il_win;
    s_il_timeout |=> s_il_raised;
  endproperty
  a_il_win: assert property (p_il_win)
    else $error("interlock alert missing at window end");

  property p_il_block;
    il_reg && state_reg == ST_DEEN |=> state_reg != ST_EN;
  endproperty
  a_il_block: assert property (p_il_block)
    else $error("energized during interlock");

  property p_il_fast;
    il_watch_reg && both_act |=> il_reg;
  endproperty
  a_il_fast: assert property (p_il_fast)
    else $error("early re-activation did not raise interlock");

  property p_il_clr;
    $fell(il_reg) |-> $past(both_off) && $past(clr_cnt_reg) == IL_CLR_CYC - 1;
  endproperty
  a_il_clr: assert property (p_il_clr)
    else $error("interlock cleared before rest time");

  property p_init_err;
    state_reg == ST_INIT && init_err_i |=> state_reg == ST_ERR && error_o;
  endproperty
  a_init_err: assert property (p_init_err)
    else $error("init error did not enter error state");

endmodule // dcsm_monitor
